// ### design/fecmd_defs.vh
// constants for the flash erase and extended error command block
//
// Functional notes
// - erase opcode only when erase feature enabled
// - host loads start address and count first
// - count zero erases 256 sectors
// - linear address built from four task registers
// - unit register bit 6 picks linear addressing
// - success clears busy and error, sets ready
// - unsupported erase reports abort bit 2
// - failure reloads address registers with failed sector
// - address not found, also without valid geometry
// - out of range gives exactly one of two
// - abort allowed when action cannot complete
// - media error sets bit 0
// - error end sets ready, fault, error status
// - query opcode takes no inputs but unit bit
// - query puts cause code in error register
// - codes 00h none, 01h self-test passed
// - codes 10h, 11h, 18h for id and checksum
// - codes 1Fh, 20h, 21h for abort and invalid
// - codes 27h, 2Fh, 3Ah; rest reserved
// - diagnostic codes, 03h erase fail, 09h misc
// - voltage 35h/36h, corrupted format 0Ch and others
// - query reports cause of preceding command
// - error registers held until next command
`ifndef FECMD_DEFS_VH
`define FECMD_DEFS_VH

// register offsets on the plain port
`define FEC_OFS_ERR_FEAT   4'h1
`define FEC_OFS_COUNT      4'h2
`define FEC_OFS_ADDR_LO    4'h3
`define FEC_OFS_ADDR_MID   4'h4
`define FEC_OFS_ADDR_HI    4'h5
`define FEC_OFS_UNIT       4'h6
`define FEC_OFS_CMD_STAT   4'h7
`define FEC_OFS_DEV_CTRL   4'he

// opcodes
`define FEC_OP_ERASE       8'hc0
`define FEC_OP_QUERY       8'h03

// bit positions
`define FEC_UNIT_LBA_BIT   6
`define FEC_UNIT_SEL_BIT   4
`define FEC_CTRL_SRST_BIT  2
`define FEC_ERR_MED_BIT    0
`define FEC_ERR_ABORT_FLAG_BIT   2
`define FEC_ERR_ADDRESS_NOT_FOUND_FLAG_BIT   4

// error register images
`define FEC_ERR_NONE       8'h00
`define FEC_ERR_MED        8'h01
`define FEC_ERR_ABORT_FLAG       8'h04
`define FEC_ERR_ADDRESS_NOT_FOUND_FLAG       8'h10

// extended cause codes
`define FEC_CC_NONE        8'h00
`define FEC_CC_SELFTEST_OK 8'h01
`define FEC_CC_ERASE_FAIL  8'h03
`define FEC_CC_DIAG_FAIL   8'h05
`define FEC_CC_MISC        8'h09
`define FEC_CC_BAD_FORMAT  8'h0c
`define FEC_CC_ID_NF       8'h10
`define FEC_CC_UNCORR      8'h11
`define FEC_CC_CORRECTED   8'h18
`define FEC_CC_XFER_ABORT  8'h1f
`define FEC_CC_BAD_CMD     8'h20
`define FEC_CC_BAD_ADDR    8'h21
`define FEC_CC_WPROTECT    8'h27
`define FEC_CC_OVERFLOW    8'h2f
`define FEC_CC_DIAG_FAIL2  8'h30
`define FEC_CC_SUPPLY_V    8'h35
`define FEC_CC_INTERNAL_V  8'h36
`define FEC_CC_SPARES_OUT  8'h3a

// media result encodings
`define FEC_MR_OK          3'h0
`define FEC_MR_ERASE_FAIL  3'h1
`define FEC_MR_UNCORR      3'h2
`define FEC_MR_ID_NF       3'h3
`define FEC_MR_WPROTECT    3'h4
`define FEC_MR_FAULT       3'h5
`define FEC_MR_VOLTAGE     3'h6
`define FEC_MR_SPARES      3'h7

// reset values
`define FEC_RST_BYTE       8'h00
`define FEC_RST_UNIT       8'ha0

`endif

// ### design/fecmd_addr_step.v
// next sector address in linear or geometry form
`timescale 1ns/1ns
`include "fecmd_defs.vh"
module fecmd_addr_step #(
    parameter [7:0] SECTORS_PER_TRACK = 8'h3f,
    parameter [4:0] HEAD_COUNT        = 5'h10
) (
    // current address and mode
    input  wire [27:0] cur_addr,
    input  wire        lba_mode,
    // following sector
    output reg  [27:0] next_addr
);
    // geometry packing matches the task registers: head, cylinder, sector
    always @* begin
        next_addr = cur_addr + 28'h1;
        if (!lba_mode) begin
            if (cur_addr[7:0] != SECTORS_PER_TRACK) begin
                next_addr = {cur_addr[27:8], cur_addr[7:0] + 8'h01};
            end else if ({1'b0, cur_addr[27:24]} != HEAD_COUNT - 5'h01) begin
                next_addr = {cur_addr[27:24] + 4'h1, cur_addr[23:8], 8'h01};
            end else begin
                next_addr = {4'h0, cur_addr[23:8] + 16'h0001, 8'h01};
            end
        end
    end
endmodule

// ### design/fecmd_cause_map.v
// maps a media result onto error bits and extended cause code
`timescale 1ns/1ns
`include "fecmd_defs.vh"
module fecmd_cause_map (
    // media result
    input  wire [2:0] result,
    // translated outcome
    output reg  [7:0] err_bits,
    output reg  [7:0] cause,
    output reg        fault
);
    always @* begin
        err_bits = `FEC_ERR_ABORT_FLAG;
        cause    = `FEC_CC_MISC;
        fault    = 1'b0;
        case (result)
            `FEC_MR_ERASE_FAIL: begin
                err_bits = `FEC_ERR_MED;
                cause    = `FEC_CC_ERASE_FAIL;
            end
            `FEC_MR_UNCORR: begin
                err_bits = `FEC_ERR_MED;
                cause    = `FEC_CC_UNCORR;
            end
            `FEC_MR_ID_NF: begin
                err_bits = `FEC_ERR_ADDRESS_NOT_FOUND_FLAG;
                cause    = `FEC_CC_ID_NF;
            end
            `FEC_MR_WPROTECT: cause = `FEC_CC_WPROTECT;
            `FEC_MR_FAULT: fault = 1'b1;
            `FEC_MR_VOLTAGE: cause = `FEC_CC_SUPPLY_V;
            `FEC_MR_SPARES: cause = `FEC_CC_SPARES_OUT;
            `FEC_MR_OK: begin
                err_bits = `FEC_ERR_NONE;
                cause    = `FEC_CC_NONE;
            end
            default: cause = `FEC_CC_MISC;
        endcase
    end
endmodule

// ### design/fecmd_top.v
// task-file command engine for multi-sector erase and extended error query
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "fecmd_defs.vh"
module fecmd_top #(
    parameter        ERASE_FEATURE_EN  = 1,
    parameter        UNIT_ID           = 0,
    parameter [7:0]  SECTORS_PER_TRACK = 8'h3f,
    parameter [4:0]  HEAD_COUNT        = 5'h10,
    parameter [16:0] CYLINDER_COUNT    = 17'h00400,
    parameter [27:0] MAX_LBA           = 28'h00fbfff
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // geometry state from the setup logic
    input  wire        geometry_valid,
    // media sector erase port
    output reg         media_req,
    output reg  [27:0] media_addr,
    output reg         media_lba,
    input  wire        media_done,
    input  wire [2:0]  media_result,
    // status mirror
    output wire        busy_flag,
    output reg         cmd_done
);
    localparam [4:0] ST_IDLE   = 5'b00001;
    localparam [4:0] ST_CHECK  = 5'b00010;
    localparam [4:0] ST_ISSUE  = 5'b00100;
    localparam [4:0] ST_WAIT   = 5'b01000;
    localparam [4:0] ST_FINISH = 5'b10000;

    // task registers
    reg  [7:0]  feature_parameter;
    reg  [7:0]  error_cause;
    reg  [7:0]  transfer_count;
    reg  [7:0]  address_low_byte;
    reg  [7:0]  address_mid_byte;
    reg  [7:0]  address_high_byte;
    reg  [7:0]  unit_select_and_top_address;
    // status bits
    reg         busy;
    reg         drive_ready_flag;
    reg         device_fault_flag;
    reg         error_flag;
    // engine state
    reg  [4:0]  state;
    reg  [27:0] cursor;
    reg         cursor_lba;
    reg  [8:0]  remaining;
    reg  [7:0]  last_cause;
    reg  [7:0]  end_err_bits;
    reg  [7:0]  end_cause;
    reg         end_fault;
    reg         end_query;
    reg         end_fail_addr;

    wire [27:0] next_addr;
    wire [7:0]  map_err_bits;
    wire [7:0]  map_cause;
    wire        map_fault;
    wire [7:0]  device_condition;
    wire        wr_cmd;
    wire        cmd_go;
    wire        soft_reset;
    wire        unit_match;
    wire [28:0] last_lba;
    wire        chs_bad;

    fecmd_addr_step #(
        .SECTORS_PER_TRACK (SECTORS_PER_TRACK),
        .HEAD_COUNT        (HEAD_COUNT)
    ) u_step (
        .cur_addr  (cursor),
        .lba_mode  (cursor_lba),
        .next_addr (next_addr)
    );

    fecmd_cause_map u_map (
        .result   (media_result),
        .err_bits (map_err_bits),
        .cause    (map_cause),
        .fault    (map_fault)
    );

    assign device_condition = {busy, drive_ready_flag, device_fault_flag, 4'h0, error_flag};
    assign busy_flag        = busy;
    assign soft_reset       = reg_wr && (reg_addr == `FEC_OFS_DEV_CTRL) && reg_wdata[`FEC_CTRL_SRST_BIT];
    assign wr_cmd           = reg_wr && (reg_addr == `FEC_OFS_CMD_STAT);
    // only the unit bit is looked at
    assign unit_match       = (unit_select_and_top_address[`FEC_UNIT_SEL_BIT] == (UNIT_ID != 0));
    // commands written while busy are dropped
    assign cmd_go           = wr_cmd && !busy && unit_match && !soft_reset;

    // one extra bit so an end past the top of the space is still seen
    assign last_lba = {1'b0, cursor} + {20'h00000, remaining} - 29'h0000001;
    assign chs_bad  = (cursor[7:0] == 8'h00) || (cursor[7:0] > SECTORS_PER_TRACK) ||
                      ({1'b0, cursor[27:24]} >= HEAD_COUNT) || ({1'b0, cursor[23:8]} >= CYLINDER_COUNT);

    // register reads answer one cycle after the strobe
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `FEC_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `FEC_OFS_ERR_FEAT: reg_rdata <= error_cause;
                `FEC_OFS_COUNT:    reg_rdata <= transfer_count;
                `FEC_OFS_ADDR_LO:  reg_rdata <= address_low_byte;
                `FEC_OFS_ADDR_MID: reg_rdata <= address_mid_byte;
                `FEC_OFS_ADDR_HI:  reg_rdata <= address_high_byte;
                `FEC_OFS_UNIT:     reg_rdata <= unit_select_and_top_address;
                `FEC_OFS_CMD_STAT: reg_rdata <= device_condition;
                default:           reg_rdata <= `FEC_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `FEC_RST_BYTE;
        end
    end

    // task register file and completion write-back
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            feature_parameter           <= `FEC_RST_BYTE;
            error_cause                 <= `FEC_RST_BYTE;
            transfer_count              <= `FEC_RST_BYTE;
            address_low_byte            <= `FEC_RST_BYTE;
            address_mid_byte            <= `FEC_RST_BYTE;
            address_high_byte           <= `FEC_RST_BYTE;
            unit_select_and_top_address <= `FEC_RST_UNIT;
        end else if (soft_reset) begin
            error_cause <= `FEC_RST_BYTE;
        end else if (state == ST_FINISH) begin
            // query answer goes into the error register
            if (end_query) begin
                error_cause <= last_cause;
            end else begin
                error_cause <= end_err_bits;
            end
            if (end_fail_addr) begin
                address_low_byte                 <= cursor[7:0];
                address_mid_byte                 <= cursor[15:8];
                address_high_byte                <= cursor[23:16];
                unit_select_and_top_address[3:0] <= cursor[27:24];
            end
        end else if (reg_wr && !busy) begin
            // while busy host writes are refused and only the completion write-back or a soft reset (error register) changes these
            case (reg_addr)
                `FEC_OFS_ERR_FEAT: feature_parameter           <= reg_wdata;
                `FEC_OFS_COUNT:    transfer_count              <= reg_wdata;
                `FEC_OFS_ADDR_LO:  address_low_byte            <= reg_wdata;
                `FEC_OFS_ADDR_MID: address_mid_byte            <= reg_wdata;
                `FEC_OFS_ADDR_HI:  address_high_byte           <= reg_wdata;
                `FEC_OFS_UNIT:     unit_select_and_top_address <= reg_wdata;
                default:           feature_parameter           <= feature_parameter;
            endcase
        end
    end

    // command engine
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state             <= ST_IDLE;
            busy              <= 1'b0;
            drive_ready_flag  <= 1'b1;
            device_fault_flag <= 1'b0;
            error_flag        <= 1'b0;
            cursor            <= 28'h0000000;
            cursor_lba        <= 1'b0;
            remaining         <= 9'h000;
            last_cause        <= `FEC_CC_NONE;
            end_err_bits      <= `FEC_ERR_NONE;
            end_cause         <= `FEC_CC_NONE;
            end_fault         <= 1'b0;
            end_query         <= 1'b0;
            end_fail_addr     <= 1'b0;
            media_req         <= 1'b0;
            media_addr        <= 28'h0000000;
            media_lba         <= 1'b0;
            cmd_done          <= 1'b0;
        end else begin
            media_req <= 1'b0;
            cmd_done  <= 1'b0;
            if (soft_reset) begin
                // soft reset abandons any command; media_done still due is ignored
                state             <= ST_IDLE;
                busy              <= 1'b0;
                drive_ready_flag  <= 1'b1;
                device_fault_flag <= 1'b0;
                error_flag        <= 1'b0;
                last_cause        <= `FEC_CC_NONE;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (cmd_go) begin
                            busy              <= 1'b1;
                            device_fault_flag <= 1'b0;
                            // a new command releases the held error
                            error_flag        <= 1'b0;
                            end_err_bits      <= `FEC_ERR_NONE;
                            end_cause         <= `FEC_CC_NONE;
                            end_fault         <= 1'b0;
                            end_query         <= 1'b0;
                            end_fail_addr     <= 1'b0;
                            // address from the four task registers
                            cursor     <= {unit_select_and_top_address[3:0], address_high_byte,
                                           address_mid_byte, address_low_byte};
                            cursor_lba <= unit_select_and_top_address[`FEC_UNIT_LBA_BIT];
                            remaining  <= (transfer_count == 8'h00) ? 9'h100 : {1'b0, transfer_count};
                            // erase only with the feature present
                            if ((reg_wdata == `FEC_OP_ERASE) && (ERASE_FEATURE_EN != 0)) begin
                                state <= ST_CHECK;
                            end else if (reg_wdata == `FEC_OP_QUERY) begin
                                end_query <= 1'b1;
                                state     <= ST_FINISH;
                            end else begin
                                end_err_bits <= `FEC_ERR_ABORT_FLAG;
                                end_cause    <= `FEC_CC_BAD_CMD;
                                state        <= ST_FINISH;
                            end
                        end
                    end
                    ST_CHECK: begin
                        state <= ST_ISSUE;
                        // out of range reports address not found only
                        if (cursor_lba) begin
                            if (cursor > MAX_LBA) begin
                                end_err_bits <= `FEC_ERR_ADDRESS_NOT_FOUND_FLAG;
                                end_cause    <= `FEC_CC_BAD_ADDR;
                                state        <= ST_FINISH;
                            end else if (last_lba > {1'b0, MAX_LBA}) begin
                                end_err_bits <= `FEC_ERR_ADDRESS_NOT_FOUND_FLAG;
                                end_cause    <= `FEC_CC_OVERFLOW;
                                state        <= ST_FINISH;
                            end
                        end else if (!geometry_valid) begin
                            end_err_bits <= `FEC_ERR_ADDRESS_NOT_FOUND_FLAG;
                            end_cause    <= `FEC_CC_ID_NF;
                            state        <= ST_FINISH;
                        end else if (chs_bad) begin
                            end_err_bits <= `FEC_ERR_ADDRESS_NOT_FOUND_FLAG;
                            end_cause    <= `FEC_CC_BAD_ADDR;
                            state        <= ST_FINISH;
                        end
                    end
                    ST_ISSUE: begin
                        media_req  <= 1'b1;
                        media_addr <= cursor;
                        media_lba  <= cursor_lba;
                        state      <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (media_done) begin
                            if (media_result != `FEC_MR_OK) begin
                                // stop at the first unrecovered sector
                                end_err_bits  <= map_err_bits;
                                end_cause     <= map_cause;
                                end_fault     <= map_fault;
                                end_fail_addr <= 1'b1;
                                state         <= ST_FINISH;
                            end else if (remaining == 9'h001) begin
                                state <= ST_FINISH;
                            end else begin
                                remaining <= remaining - 9'h001;
                                cursor    <= next_addr;
                                state     <= ST_ISSUE;
                            end
                        end
                    end
                    ST_FINISH: begin
                        // completion clears busy and sets ready
                        busy              <= 1'b0;
                        drive_ready_flag  <= 1'b1;
                        cmd_done          <= 1'b1;
                        state             <= ST_IDLE;
                        // fault and error status on error end
                        device_fault_flag <= end_fault;
                        error_flag        <= (end_err_bits != `FEC_ERR_NONE) && !end_query;
                        // cause kept for the next query only
                        last_cause        <= end_query ? `FEC_CC_NONE : end_cause;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ### testbench/fecmd_props.sv
// assertion checker for the erase and extended error command engine
`timescale 1ns/1ns
module fecmd_props #(
    parameter ERASE_FEATURE_EN = 1,
    parameter UNIT_ID          = 0
) (
    // clock and reset
    input wire       core_clk,
    input wire       reset,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // media and status
    input wire       media_req,
    input wire       media_lba,
    input wire       media_done,
    input wire       busy_flag,
    input wire       cmd_done
);
    reg  unit_sel;
    reg  lba_sel;
    wire accept;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // mirror of the unit register bits; writes while busy are refused by the engine
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            unit_sel <= 1'b0;
            lba_sel  <= 1'b0;
        end else if (reg_wr && reg_addr == 4'h6 && !busy_flag) begin
            unit_sel <= reg_wdata[4];
            lba_sel  <= reg_wdata[6];
        end
    end
    assign accept = reg_wr && reg_addr == 4'h7 && !busy_flag && (unit_sel == (UNIT_ID != 0));

    a_accept_busy: assert property (accept |=> busy_flag) else $error("busy not raised");
    a_done_busy: assert property (cmd_done |-> $past(busy_flag) && !busy_flag) else $error("done without busy drop");
    a_query_time: assert property (accept && reg_wdata == 8'h03 |-> ##1 busy_flag ##1 cmd_done)
        else $error("query not done in two cycles");
    a_bad_opcode: assert property (accept && reg_wdata != 8'h03 && (reg_wdata != 8'hc0 || ERASE_FEATURE_EN == 0)
        |-> ##2 cmd_done) else $error("invalid opcode not ended");
    a_erase_start: assert property (accept && reg_wdata == 8'hc0 && ERASE_FEATURE_EN != 0
        |-> (##3 (media_req && media_lba == lba_sel)) or (##3 cmd_done)) else $error("erase start wrong");
    a_sector_step: assert property (media_done && busy_flag |-> ##2 (media_req || cmd_done))
        else $error("no step after sector");
    a_req_pulse: assert property (media_req |-> busy_flag ##1 !media_req) else $error("bad sector request");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
endmodule

bind fecmd_top fecmd_props #(.ERASE_FEATURE_EN(ERASE_FEATURE_EN), .UNIT_ID(UNIT_ID)) fecmd_props_inst (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .media_req(media_req), .media_lba(media_lba),
    .media_done(media_done), .busy_flag(busy_flag), .cmd_done(cmd_done));

// ### testbench/fecmd_media_model.sv
// sector erase media model with settable latency and one failing sector
`timescale 1ns/1ns
module fecmd_media_model (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // request side
    input  wire        media_req,
    input  wire [27:0] media_addr,
    // scenario control
    input  wire [7:0]  delay,
    input  wire [27:0] fail_addr,
    input  wire [2:0]  fail_res,
    // answer side
    output reg         media_done,
    output reg  [2:0]  media_result
);
    reg       busy;
    reg [7:0] cnt;
    reg [2:0] res;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy         <= 1'b0;
            cnt          <= 8'h00;
            res          <= 3'h0;
            media_done   <= 1'b0;
            media_result <= 3'h7;
        end else begin
            media_done <= 1'b0;
            if (media_req) begin
                busy <= 1'b1;
                cnt  <= delay;
                res  <= (media_addr == fail_addr) ? fail_res : 3'h0;
            end else if (busy && cnt == 8'h00) begin
                busy         <= 1'b0;
                media_done   <= 1'b1;
                media_result <= res;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end else begin
                // result is only meaningful beside done, so keep it moving
                media_result <= ~media_result;
            end
        end
    end
endmodule

// ### testbench/fecmd_tb_top.sv
// register-level bench for the erase and extended error command engine
`timescale 1ns/1ns
module fecmd_tb_top;
    localparam [55:0] ERR_T = {8'h04, 8'h04, 8'h04, 8'h04, 8'h10, 8'h01, 8'h01};
    localparam [55:0] ST_T  = {8'h41, 8'h41, 8'h61, 8'h41, 8'h41, 8'h41, 8'h41};
    localparam [55:0] CC_T  = {8'h3a, 8'h35, 8'h09, 8'h27, 8'h10, 8'h11, 8'h03};
    reg         core_clk = 1'b0;
    reg         reset = 1'b1;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         geometry_valid = 1'b0;
    reg  [7:0]  m_delay = 8'h00;
    reg  [27:0] m_fail_addr = 28'h0000000;
    reg  [2:0]  m_fail_res = 3'h0;
    wire [7:0]  reg_rdata;
    wire        media_req, media_lba, media_done, busy_flag, cmd_done;
    wire [27:0] media_addr;
    wire [2:0]  media_result;
    integer     error_cnt = 0;
    integer     num_checks = 0;
    integer     i;
    reg  [28:0] req_q[$];

    fecmd_top fecmd_top_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .geometry_valid(geometry_valid),
        .media_req(media_req), .media_addr(media_addr), .media_lba(media_lba), .media_done(media_done),
        .media_result(media_result), .busy_flag(busy_flag), .cmd_done(cmd_done));
    fecmd_media_model fecmd_media_model_inst (.core_clk(core_clk), .reset(reset), .media_req(media_req),
        .media_addr(media_addr), .delay(m_delay), .fail_addr(m_fail_addr), .fail_res(m_fail_res),
        .media_done(media_done), .media_result(media_result));

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (media_req) req_q.push_back({media_lba, media_addr});
    end

    task test_done;
        begin
            if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input string n, input [28:0] e, input [28:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("BAD %s exp %h got %h", n, e, g);
            end
        end
    endtask
    // strobes are dropped a full cycle before the next one may rise
    task wr(input [3:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task rc(input [3:0] a, input [7:0] e);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            chk($sformatf("reg%0h", a), {21'h0, e}, {21'h0, reg_rdata});
            @(posedge core_clk);
        end
    endtask
    // host waits out busy before the next command
    task fin;
        integer n;
        begin
            n = 0;
            #1;
            while (cmd_done !== 1'b1 && n < 3000) begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            chk("cmd_done", 29'h1, {28'h0, cmd_done});
            @(posedge core_clk);
        end
    endtask
    task query(input [7:0] e);
        begin
            wr(4'h7, 8'h03);
            fin;
            rc(4'h1, e);
        end
    endtask
    task erase(input [7:0] c, input [7:0] lo, input [7:0] mi, input [7:0] hi, input [7:0] u);
        begin
            req_q.delete();
            wr(4'h2, c);
            wr(4'h3, lo);
            wr(4'h4, mi);
            wr(4'h5, hi);
            wr(4'h6, u);
            wr(4'h7, 8'hc0);
        end
    endtask

    initial begin
        #2400000;
        error_cnt = error_cnt + 1;
        test_done;
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (i = 1; i < 9; i = i + 1) rc(i[3:0], (i == 6) ? 8'ha0 : (i == 7) ? 8'h40 : 8'h00);
        // slow media, with a refused count write while busy
        m_delay <= 8'h1e;
        erase(8'h02, 8'hde, 8'hbc, 8'h0a, 8'h40);
        wr(4'h2, 8'h07);
        fin;
        chk("sector0", {1'b1, 28'h00abcde}, req_q[0]);
        chk("sector1", {1'b1, 28'h00abcdf}, req_q[1]);
        chk("nsect", 29'h2, req_q.size());
        rc(4'h7, 8'h40);
        rc(4'h2, 8'h02);
        query(8'h00);
        m_delay <= 8'h00;
        erase(8'h00, 8'h00, 8'h01, 8'h00, 8'h40);
        fin;
        chk("nsect", 29'h100, req_q.size());
        chk("last", {1'b1, 28'h00001ff}, req_q[255]);
        // every media failure kind on the second of three sectors
        m_fail_addr <= 28'h0000006;
        for (i = 1; i < 8; i = i + 1) begin
            m_fail_res <= i[2:0];
            erase(8'h03, 8'h05, 8'h00, 8'h00, 8'h40);
            fin;
            chk("nsect", 29'h2, req_q.size());
            rc(4'h1, ERR_T[8*(i-1)+:8]);
            rc(4'h7, ST_T[8*(i-1)+:8]);
            rc(4'h3, 8'h06);
            query(CC_T[8*(i-1)+:8]);
            rc(4'h7, 8'h40);
            query(8'h00);
        end
        m_fail_res <= 3'h0;
        wr(4'h7, 8'h55);
        fin;
        rc(4'h1, 8'h04);
        rc(4'h7, 8'h41);
        query(8'h20);
        erase(8'h01, 8'h00, 8'hc0, 8'h0f, 8'h40);
        fin;
        rc(4'h1, 8'h10);
        rc(4'h7, 8'h41);
        query(8'h21);
        erase(8'h02, 8'hff, 8'hbf, 8'h0f, 8'h40);
        fin;
        query(8'h2f);
        erase(8'h01, 8'h01, 8'h00, 8'h00, 8'h00);
        fin;
        rc(4'h1, 8'h10);
        wr(4'he, 8'h04);
        rc(4'h7, 8'h40);
        rc(4'h1, 8'h00);
        // a query for the other unit must leave the engine idle
        wr(4'h6, 8'h10);
        wr(4'h7, 8'h03);
        rc(4'h7, 8'h40);
        geometry_valid <= 1'b1;
        erase(8'h02, 8'h3f, 8'h00, 8'h00, 8'h00);
        fin;
        chk("chs0", {1'b0, 28'h000003f}, req_q[0]);
        chk("chs1", {1'b0, 28'h1000001}, req_q[1]);
        rc(4'h7, 8'h40);
        test_done;
    end
endmodule
